// ===== hw/dbm_pkg.sv
// Function
// - Cable strap copies into coax bit 7.
// - Lane strap loads bridge control bits 3:2.
// - Clock strap sets continuous bit and mode.
// - Disable strap maps to reset control bit 7.
// - Splitter strap sets transmit mode, audio split.
// - Strap modes 4-7 (clock bit 2): discontinuous.
// - Clock mode field picks link reference clock.
// - DSI reference mode with continuous clock runs link from DSI clock.
// - Pixel rate is DSI rate times lanes over 12.
// - Packet codes decode sync starts and ends.
// - Vertical width counts horizontal starts in lines.
// - Horizontal width counts pixels from line start to end packet.
// - Sync events use configured pulse widths.
// - Event enable and widths come from config.
// - External mode uses reference input A.
// - Internal mode uses always-on clock, debug only.
// - Per-port mode: port 0 A, port 1 B.
// - Dual input alternates port 0, port 1.
// - Left/right images merge a whole line at a time.
// - Optional side-by-side merge, left then right.
// - Dual input needs dual link, continuous clock.
// - Straps latch at power-up, software overrides later.
`default_nettype none
package dbm_pkg;
  // ------------------------------------------------------------
  // Register field positions
  // ------------------------------------------------------------
  localparam int CTL_CONT_CLK_BIT = 7;
  localparam int CTL_LANES_LSB = 2;
  localparam int CTL_DUAL_DSI_BIT = 0;
  localparam int CFG2_CLK_MODE_LSB = 0;
  localparam int CFG2_LR_MERGE_BIT = 2;
  localparam int DUAL_COAX_BIT = 7;
  localparam int DUAL_TXMODE_LSB = 0;
  localparam int AUD_SPLIT_BIT = 4;
  localparam int RST_DSI_DIS_BIT = 7;
  // Strap fields inside the decoded 3-bit mode number
  localparam int S1_CLOCK_BIT = 2;
  localparam int S1_COAX_BIT = 1;
  localparam int S1_DISABLE_BIT = 0;
  localparam int S0_SPLIT_BIT = 2;
  localparam int S0_LANES_LSB = 0;
  // ------------------------------------------------------------
  // Encodings, reset values and counts
  // ------------------------------------------------------------
  localparam logic [1:0] CLKM_DSI = 2'h0;
  localparam logic [1:0] CLKM_EXT = 2'h1;
  localparam logic [1:0] CLKM_INT = 2'h2;
  localparam logic [1:0] CLKM_EXT2 = 2'h3;
  localparam logic [2:0] TXM_NORMAL = 3'h0;
  localparam logic [2:0] TXM_DUAL = 3'h3;
  localparam logic [2:0] TXM_SPLIT = 3'h5;
  localparam logic [7:0] PKT_VSS = 8'h01;
  localparam logic [7:0] PKT_VSE = 8'h11;
  localparam logic [7:0] PKT_HSS = 8'h21;
  localparam logic [7:0] PKT_HSE = 8'h31;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
  localparam int PCLK_DIV = 12;
  localparam int PIX_W = 24;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] bridge_control_reg;
    logic [7:0] bridge_config_second_reg;
    logic [7:0] dual_link_control_reg;
    logic [7:0] audio_config_reg;
    logic [7:0] reset_control_reg;
  } dbm_regs_t;
  typedef struct packed {
    logic sync_evt_en;
    logic [7:0] horizontal_sync_width_cfg;
    logic [7:0] vertical_sync_width_cfg;
    logic [11:0] line_len;
  } dbm_dsi_cfg_t;
  typedef struct packed {
    logic stb;
    logic [7:0] code;
  } dbm_pkt_t;
  typedef struct packed {
    logic [PIX_W-1:0] p0;
    logic [PIX_W-1:0] p1;
  } dbm_pair_t;
  typedef enum logic [1:0] {RS_DSI, RS_PIN_A, RS_PIN_B, RS_INTERNAL} dbm_refsrc_t;
  typedef enum logic [1:0] {MG_FIRST, MG_SECOND, MG_RIGHT} dbm_mg_t;
endpackage
`default_nettype wire

// ===== hw/dbm_sync2.sv
`default_nettype none
module dbm_sync2 #(
  parameter int W = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ------------------------------------------------------------
  logic [W-1:0] meta_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== hw/dbm_fifo.sv
`default_nettype none
module dbm_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  // ------------------------------------------------------------
  // Flags from the occupancy count
  // ------------------------------------------------------------
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rptr_r];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;
  // Pointers wrap by power-of-two depth
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wptr_r <= wptr_r + 1'b1;
      if (pop) rptr_r <= rptr_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge ref_clk) begin
    if (push) mem[wptr_r] <= in_data;
  end
endmodule
`default_nettype wire

// ===== hw/dbm_top.sv
`default_nettype none
module dbm_top
  import dbm_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int LINE_MAX = 4096,
  parameter int FREQ_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] first_strap_input,
  input wire logic [2:0] second_strap_input,
  input wire logic sw_wr,
  input wire dbm_regs_t sw_regs,
  input wire dbm_dsi_cfg_t dsi_cfg,
  input wire logic [FREQ_W-1:0] dsi_khz,
  input wire dbm_pkt_t pkt,
  input wire logic pix_tick,
  input wire logic p0_valid,
  input wire logic [PIX_W-1:0] p0_data,
  input wire logic p1_valid,
  input wire logic [PIX_W-1:0] p1_data,
  output logic p_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [PIX_W-1:0] out_data,
  output dbm_regs_t regs_o,
  output dbm_refsrc_t ref_sel_a,
  output dbm_refsrc_t ref_sel_b,
  output logic tx_sync_dsi,
  output logic dsi_discont,
  output logic cfg_fault,
  output logic [FREQ_W-1:0] pclk_khz,
  output logic vs_o,
  output logic hs_o
);
  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  logic [5:0] strap_s;
  logic [2:0] strap0;
  logic [2:0] strap1;
  logic [1:0] strap_cnt_r;
  logic strap_load;
  dbm_regs_t regs_nxt;

  dbm_sync2 #(.W(6)) u_strap_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({second_strap_input, first_strap_input}),
    .q(strap_s)
  );
  assign strap0 = strap_s[2:0];
  assign strap1 = strap_s[5:3];
  // Load once the synchroniser has filled after reset release
  assign strap_load = (strap_cnt_r == STRAP_LOAD_CNT);

  // Strap decode overrides the register image once; software after
  always_comb begin
    regs_nxt = regs_o;
    if (strap_load) begin
      regs_nxt.dual_link_control_reg[DUAL_COAX_BIT] = strap1[S1_COAX_BIT];
      regs_nxt.bridge_control_reg[CTL_LANES_LSB +: 2] = strap0[S0_LANES_LSB +: 2];
      regs_nxt.bridge_control_reg[CTL_CONT_CLK_BIT] = ~strap1[S1_CLOCK_BIT];
      regs_nxt.bridge_config_second_reg[CFG2_CLK_MODE_LSB +: 2] =
        strap1[S1_CLOCK_BIT] ? CLKM_EXT : CLKM_DSI;
      regs_nxt.reset_control_reg[RST_DSI_DIS_BIT] = strap1[S1_DISABLE_BIT];
      regs_nxt.dual_link_control_reg[DUAL_TXMODE_LSB +: 3] =
        strap0[S0_SPLIT_BIT] ? TXM_SPLIT : TXM_NORMAL;
      regs_nxt.audio_config_reg[AUD_SPLIT_BIT] = strap0[S0_SPLIT_BIT];
    end else if (sw_wr) begin
      regs_nxt = sw_regs;
    end
  end

  // Register image; counter parks past the load value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regs_o <= {5{REG_RST}};
      strap_cnt_r <= '0;
    end else if (ce) begin
      regs_o <= regs_nxt;
      if (strap_cnt_r != 2'h3) strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Clock mode decode
  // ------------------------------------------------------------
  logic cont_clk;
  logic [1:0] clk_mode;
  logic [2:0] nlanes;
  logic dsi_dis;
  logic dual_en;
  logic lr_en;
  logic [2:0] tx_mode;
  dbm_refsrc_t sel_a_nxt;
  dbm_refsrc_t sel_b_nxt;
  logic [FREQ_W+2:0] pclk_prod;

  assign cont_clk = regs_o.bridge_control_reg[CTL_CONT_CLK_BIT];
  assign clk_mode = regs_o.bridge_config_second_reg[CFG2_CLK_MODE_LSB +: 2];
  assign nlanes = {1'b0, regs_o.bridge_control_reg[CTL_LANES_LSB +: 2]} + 3'h1;
  assign dsi_dis = regs_o.reset_control_reg[RST_DSI_DIS_BIT];
  assign dual_en = regs_o.bridge_control_reg[CTL_DUAL_DSI_BIT];
  assign lr_en = regs_o.bridge_config_second_reg[CFG2_LR_MERGE_BIT];
  assign tx_mode = regs_o.dual_link_control_reg[DUAL_TXMODE_LSB +: 3];
  // Reference source per output port
  assign sel_a_nxt = (clk_mode == CLKM_DSI) ? RS_DSI :
                     (clk_mode == CLKM_INT) ? RS_INTERNAL : RS_PIN_A;
  assign sel_b_nxt = (clk_mode == CLKM_EXT2) ? RS_PIN_B : sel_a_nxt;
  assign pclk_prod = (FREQ_W+3)'(dsi_khz) * (FREQ_W+3)'(nlanes);

  // Mode outputs; the fault flag warns of unsupported combinations
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ref_sel_a <= RS_DSI;
      ref_sel_b <= RS_DSI;
      tx_sync_dsi <= 1'b0;
      dsi_discont <= 1'b0;
      cfg_fault <= 1'b0;
      pclk_khz <= '0;
    end else if (ce) begin
      ref_sel_a <= sel_a_nxt;
      ref_sel_b <= sel_b_nxt;
      tx_sync_dsi <= (clk_mode == CLKM_DSI) && cont_clk;
      dsi_discont <= ~cont_clk;
      cfg_fault <= ((clk_mode == CLKM_DSI) && !cont_clk) ||
                   (dual_en && (!cont_clk || tx_mode != TXM_DUAL));
      pclk_khz <= FREQ_W'(pclk_prod / (FREQ_W+3)'(PCLK_DIV));
    end
  end

  // ------------------------------------------------------------
  // Sync regeneration
  // ------------------------------------------------------------
  logic evt_mode;
  logic pkt_vss;
  logic pkt_vse;
  logic pkt_hss;
  logic pkt_hse;
  logic hss_any;
  logic [7:0] vlines_r;
  logic [7:0] vlines_nxt;
  logic [7:0] hcnt_r;
  logic [7:0] hcnt_nxt;
  logic vs_nxt;
  logic hs_nxt;

  assign evt_mode = dsi_cfg.sync_evt_en;
  assign pkt_vss = pkt.stb && pkt.code == PKT_VSS;
  assign pkt_vse = pkt.stb && pkt.code == PKT_VSE;
  assign pkt_hss = pkt.stb && pkt.code == PKT_HSS;
  assign pkt_hse = pkt.stb && pkt.code == PKT_HSE;
  // Both vertical codes open a line, the end code only outside event mode
  assign hss_any = pkt_vss | pkt_hss | (pkt_vse & ~evt_mode);

  // Vertical pulse, width in lines
  always_comb begin
    vs_nxt = vs_o;
    vlines_nxt = vlines_r;
    if (dsi_dis) begin
      vs_nxt = 1'b0;
      vlines_nxt = '0;
    end else if (pkt_vss) begin
      vs_nxt = 1'b1;
      vlines_nxt = 8'h01;
    end else if (evt_mode) begin
      if (vs_o && hss_any) begin
        if (vlines_r >= dsi_cfg.vertical_sync_width_cfg) vs_nxt = 1'b0;
        else vlines_nxt = vlines_r + 8'h01;
      end
    end else if (pkt_vse) begin
      vs_nxt = 1'b0;
    end else if (vs_o && hss_any) begin
      vlines_nxt = vlines_r + 8'h01;
    end
  end

  // Horizontal pulse, width in pixel ticks
  always_comb begin
    hs_nxt = hs_o;
    hcnt_nxt = hcnt_r;
    if (dsi_dis) begin
      hs_nxt = 1'b0;
      hcnt_nxt = '0;
    end else if (hss_any) begin
      hs_nxt = 1'b1;
      hcnt_nxt = '0;
    end else if (hs_o && evt_mode) begin
      if (pix_tick) begin
        if (hcnt_r + 8'h01 >= dsi_cfg.horizontal_sync_width_cfg) hs_nxt = 1'b0;
        else hcnt_nxt = hcnt_r + 8'h01;
      end
    end else if (hs_o) begin
      if (pix_tick) hcnt_nxt = hcnt_r + 8'h01;
      if (pkt_hse) hs_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vs_o <= 1'b0;
      hs_o <= 1'b0;
      vlines_r <= '0;
      hcnt_r <= '0;
    end else if (ce) begin
      vs_o <= vs_nxt;
      hs_o <= hs_nxt;
      vlines_r <= vlines_nxt;
      hcnt_r <= hcnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // Dual-port merge
  // ------------------------------------------------------------
  dbm_pair_t pair_r;
  logic pair_full_r;
  logic take;
  logic consume;
  dbm_mg_t mg_r;
  dbm_mg_t mg_nxt;
  logic [11:0] pos_r;
  logic [11:0] pos_nxt;
  logic [PIX_W-1:0] line_mem [LINE_MAX];
  logic [PIX_W-1:0] push_data;
  logic push_valid;
  logic push_ready;
  logic line_end;
  logic f_valid;
  logic f_pop;
  logic [PIX_W-1:0] f_data;

  // Pair is taken only with both ports valid in dual mode
  assign take = ce && p_ready && p0_valid && (p1_valid || !dual_en) && !dsi_dis;
  assign line_end = (pos_r == dsi_cfg.line_len - 12'h001);
  assign push_valid = pair_full_r || (mg_r == MG_RIGHT);
  assign push_data = (mg_r == MG_RIGHT) ? line_mem[pos_r] :
                     (mg_r == MG_SECOND) ? pair_r.p1 : pair_r.p0;

  // Merge sequencing: port 0 first, then port 1 or the stored right line
  always_comb begin
    mg_nxt = mg_r;
    pos_nxt = pos_r;
    consume = 1'b0;
    if (ce && push_valid && push_ready) begin
      unique case (mg_r)
        MG_FIRST: begin
          if (!dual_en) begin
            consume = 1'b1;
          end else if (lr_en) begin
            consume = 1'b1;
            pos_nxt = line_end ? '0 : pos_r + 12'h001;
            if (line_end) mg_nxt = MG_RIGHT;
          end else begin
            mg_nxt = MG_SECOND;
          end
        end
        MG_SECOND: begin
          consume = 1'b1;
          mg_nxt = MG_FIRST;
        end
        MG_RIGHT: begin
          pos_nxt = line_end ? '0 : pos_r + 12'h001;
          if (line_end) mg_nxt = MG_FIRST;
        end
        default: mg_nxt = MG_FIRST;
      endcase
    end
  end

  // Ready is registered, so the pair stage takes at most every other cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pair_full_r <= 1'b0;
      p_ready <= 1'b0;
      mg_r <= MG_FIRST;
      pos_r <= '0;
    end else if (ce) begin
      pair_full_r <= take | (pair_full_r & ~consume);
      p_ready <= ~(take | (pair_full_r & ~consume)) & (mg_nxt != MG_RIGHT);
      mg_r <= mg_nxt;
      pos_r <= pos_nxt;
    end
  end

  // Pair data and right-line store
  always_ff @(posedge ref_clk) begin
    if (take) pair_r <= '{p0: p0_data, p1: p1_data};
    if (consume && mg_r == MG_FIRST && lr_en) line_mem[pos_r] <= pair_r.p1;
  end

  dbm_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Output register stage; the sink can stall back into the FIFO
  assign f_pop = !out_valid || out_ready;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce && f_pop) begin
      out_valid <= f_valid;
      out_data <= f_data;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_coax_strap: assert property (ce && strap_load |=> regs_o.dual_link_control_reg[7] ==
    $past(strap1[S1_COAX_BIT])) else $error("coax bit not loaded");
  a_lane_strap: assert property (ce && strap_load |=> regs_o.bridge_control_reg[3:2] ==
    $past(strap0[1:0])) else $error("lane field not loaded");
  a_clock_strap: assert property (ce && strap_load |=> (regs_o.bridge_control_reg[7] ==
    (regs_o.bridge_config_second_reg[1:0] == CLKM_DSI))) else $error("clock strap");
  a_split_strap: assert property (ce && strap_load |=> regs_o.audio_config_reg[4] ==
    $past(strap0[2]) && regs_o.reset_control_reg[7] == $past(strap1[0]))
    else $error("split or disable strap");
  a_ref_pick: assert property (ce && clk_mode == CLKM_EXT2 ##1 ce |-> ref_sel_a == RS_PIN_A &&
    ref_sel_b == RS_PIN_B) else $error("per-port reference wrong");
  a_dsi_sync: assert property (ce && clk_mode == CLKM_DSI && cont_clk |=> tx_sync_dsi)
    else $error("link not locked to DSI clock");
  a_pclk_calc: assert property (ce && $stable(dsi_khz) && $stable(nlanes) |=>
    pclk_khz == FREQ_W'($past(pclk_prod) / 12)) else $error("pixel rate wrong");
  a_vs_start: assert property (ce && pkt_vss && !dsi_dis |=> vs_o && vlines_r == 8'h01)
    else $error("vertical start missed");
  a_vs_end: assert property (ce && !evt_mode && pkt_vse && !dsi_dis |=> !vs_o)
    else $error("vertical end missed");
  a_hs_end: assert property (ce && !evt_mode && hs_o && pkt_hse && !hss_any && !dsi_dis
    |=> !hs_o) else $error("horizontal end missed");
  a_evt_hwidth: assert property (ce && evt_mode && hs_o && pix_tick && !hss_any && !dsi_dis &&
    hcnt_r + 8'h01 >= dsi_cfg.horizontal_sync_width_cfg |=> !hs_o)
    else $error("event pulse too long");
  a_alt_order: assert property (ce && dual_en && !lr_en && mg_r == MG_FIRST && push_valid &&
    push_ready |=> mg_r == MG_SECOND) else $error("port order broken");

  c_dual_alt: cover property (mg_r == MG_SECOND ##1 mg_r == MG_FIRST);
  c_lr_right: cover property (mg_r == MG_RIGHT);
  c_vs_pulse: cover property ($rose(vs_o) ##[1:300] $fell(vs_o));
  c_full_stall: cover property (out_valid && !out_ready && !push_ready);
endmodule
`default_nettype wire

// ===== verif/dbm_dsi_src.sv
`default_nettype none
// ----------------------------------------
// Pixel source on both input ports
// ----------------------------------------
module dbm_dsi_src
  import dbm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [7:0] n_pairs,
  input wire logic dual,
  input wire logic blocked,
  input wire logic p_ready,
  output logic took,
  output logic p0_valid,
  output logic [PIX_W-1:0] p0_data,
  output logic p1_valid,
  output logic [PIX_W-1:0] p1_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sent = 8'h00;
  logic took_r = 1'b0;
  // Same take condition as the bridge applies
  assign took = ce && p_ready && p0_valid && (p1_valid || !dual) && !blocked;
  // Count pairs handed over
  always @(posedge ref_clk) begin
    took_r <= took;
    if (!rst_n || !run) sent <= 8'h00;
    else if (took) sent <= sent + 8'h01;
  end
  initial begin
    p0_valid = 1'b0;
    p1_valid = 1'b0;
    p0_data = '0;
    p1_data = '0;
  end
  // In dual mode both ports present a pair together, no skew
  // Idle lines show the inverse of the last word, not a stale copy
  always @(negedge ref_clk) begin
    if (!p0_valid || took_r) begin
      if (rst_n && run && sent < n_pairs && ($urandom % 4) != 0) begin
        p0_valid = 1'b1;
        p1_valid = dual;
        p0_data = PIX_W'($urandom);
        p1_data = PIX_W'($urandom);
      end else begin
        p0_valid = 1'b0;
        p1_valid = 1'b0;
        p0_data = ~p0_data;
        p1_data = ~p1_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/dbm_top_tb.sv
`default_nettype none
module dbm_top_tb
  import dbm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LLEN = 4;
  logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sw_wr = 1'b0, pix_tick = 1'b0;
  logic out_ready = 1'b0, run = 1'b0, took, p_ready, out_valid;
  logic p0_valid, p1_valid, tx_sync_dsi, dsi_discont, cfg_fault, vs_o, hs_o;
  logic [2:0] s0 = 3'h0, s1 = 3'h0;
  logic [1:0] mode = 2'h0;
  logic [15:0] khz = 16'h0000;
  logic [15:0] pclk_khz;
  logic [PIX_W-1:0] p0_data, p1_data, out_data;
  logic [PIX_W-1:0] eq[$], rq[$];
  dbm_regs_t sw_regs = '0, regs_o;
  dbm_dsi_cfg_t cfg = {1'b0, 8'h03, 8'h02, 12'h004};
  dbm_pkt_t pkt = '0;
  dbm_refsrc_t ref_sel_a, ref_sel_b;
  int n_mismatch = 0, n_checks = 0, n_took = 0;
  logic [7:0] codes[6] = '{PKT_VSS, PKT_HSE, PKT_HSS, PKT_HSE, PKT_VSE, PKT_HSE};
  logic [1:0] vh[6] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0};
  dbm_top #(.FIFO_DEPTH(4)) dbm_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .first_strap_input(s0), .second_strap_input(s1), .sw_wr(sw_wr), .sw_regs(sw_regs),
    .dsi_cfg(cfg), .dsi_khz(khz), .pkt(pkt), .pix_tick(pix_tick), .p0_valid(p0_valid),
    .p0_data(p0_data), .p1_valid(p1_valid), .p1_data(p1_data), .p_ready(p_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .regs_o(regs_o),
    .ref_sel_a(ref_sel_a), .ref_sel_b(ref_sel_b), .tx_sync_dsi(tx_sync_dsi),
    .dsi_discont(dsi_discont), .cfg_fault(cfg_fault), .pclk_khz(pclk_khz), .vs_o(vs_o),
    .hs_o(hs_o));
  dbm_dsi_src dbm_dsi_src_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .run(run),
    .n_pairs(8'h18), .dual(mode != 2'h0), .blocked(regs_o.reset_control_reg[7]),
    .p_ready(p_ready), .took(took), .p0_valid(p0_valid), .p0_data(p0_data),
    .p1_valid(p1_valid), .p1_data(p1_data));
  initial forever #2 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Checking and expectations
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register image that the straps should leave behind
  function automatic dbm_regs_t strap_regs(logic [2:0] a, logic [2:0] b);
    dbm_regs_t r;
    r = '0;
    r.bridge_control_reg[7] = !b[S1_CLOCK_BIT];
    r.bridge_control_reg[3:2] = a[1:0];
    r.bridge_config_second_reg[1:0] = b[S1_CLOCK_BIT] ? CLKM_EXT : CLKM_DSI;
    r.dual_link_control_reg[7] = b[S1_COAX_BIT];
    r.dual_link_control_reg[2:0] = a[S0_SPLIT_BIT] ? TXM_SPLIT : TXM_NORMAL;
    r.audio_config_reg[4] = a[S0_SPLIT_BIT];
    r.reset_control_reg[7] = b[S1_DISABLE_BIT];
    return r;
  endfunction
  task automatic chk_outs(dbm_regs_t r);
    logic [1:0] m;
    logic [7:0] c;
    dbm_refsrc_t sa;
    m = r.bridge_config_second_reg[1:0];
    c = r.bridge_control_reg;
    sa = (m == CLKM_DSI) ? RS_DSI : (m == CLKM_INT) ? RS_INTERNAL : RS_PIN_A;
    @(negedge ref_clk);
    chk("regs_o", regs_o, r);
    chk("ref_sel_a", ref_sel_a, sa);
    chk("ref_sel_b", ref_sel_b, (m == CLKM_EXT2) ? RS_PIN_B : sa);
    chk("dsi_discont", dsi_discont, !c[7]);
    chk("tx_sync_dsi", tx_sync_dsi, m == CLKM_DSI && c[7]);
    chk("pclk_khz", pclk_khz, khz * (c[3:2] + 1) / PCLK_DIV);
    // DSI reference without continuous clock is flagged as well as bad dual setups
    chk("cfg_fault", cfg_fault, (m == CLKM_DSI && !c[7]) ||
      (c[0] && (r.dual_link_control_reg[2:0] != TXM_DUAL || !c[7])));
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic wr(dbm_regs_t r);
    @(negedge ref_clk);
    sw_regs = r;
    sw_wr = 1'b1;
    @(negedge ref_clk);
    sw_wr = 1'b0;
  endtask
  task automatic pk(logic [7:0] c);
    @(negedge ref_clk);
    pkt = {1'b1, c};
    @(negedge ref_clk);
    pkt.stb = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic tick();
    @(negedge ref_clk);
    pix_tick = 1'b1;
    @(negedge ref_clk);
    pix_tick = 1'b0;
  endtask
  // Setup changes only while inputs are held off; sink stalls to fill the FIFO
  task automatic pix_run(logic [1:0] m);
    dbm_regs_t r;
    int k;
    r = '0;
    r.bridge_control_reg = {1'b1, 6'h00, m != 2'h0};
    r.bridge_config_second_reg[CFG2_LR_MERGE_BIT] = (m == 2'h2);
    r.dual_link_control_reg[2:0] = TXM_DUAL;
    r.reset_control_reg = 8'h80;
    mode = m;
    n_took = 0;
    wr(r);
    run = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("took_blocked", n_took, 0);
    r.reset_control_reg = 8'h00;
    wr(r);
    repeat (30) @(negedge ref_clk);
    chk("p_ready_full", p_ready, 1'b0);
    for (k = 0; k < 4000 && !(n_took == 24 && eq.size() == 0); k++) begin
      @(negedge ref_clk);
      out_ready = ($urandom % 3) != 0;
      ce = ($urandom % 8) != 0;
    end
    if (k == 4000) chk("drain", 0, 1);
    ce = 1'b1;
    run = 1'b0;
    out_ready = 1'b0;
  endtask
  // Expected stream built from the pairs taken; output compared as it leaves
  always @(posedge ref_clk) begin
    if (took) begin
      n_took++;
      if (mode == 2'h2) begin
        // Left pixels leave before the line is complete; right line follows
        eq.push_back(p0_data);
        rq.push_back(p1_data);
        if (rq.size() == LLEN) begin
          eq = {eq, rq};
          rq.delete();
        end
      end else begin
        eq.push_back(p0_data);
        if (mode == 2'h1) eq.push_back(p1_data);
      end
    end
    if (rst_n && ce && out_valid && out_ready) begin
      if (eq.size() == 0) chk("out_extra", 1, 0);
      else chk("out_data", out_data, eq.pop_front());
    end
  end
  // Hang guard, far beyond the expected run length
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    dbm_regs_t r;
    int i;
    void'($urandom(32'h5E94D9EA));
    for (i = 0; i < 8; i++) begin
      s1 = i[2:0];
      s0 = 3'($urandom);
      khz = 16'($urandom % 16384);
      rst_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("regs_rst", regs_o, 0);
      rst_n = 1'b1;
      repeat (5) @(negedge ref_clk);
      chk_outs(strap_regs(s0, s1));
    end
    for (i = 0; i < 16; i++) begin
      r = {$urandom, 8'($urandom)};
      r.bridge_config_second_reg[1:0] = i[1:0];
      if (i == 5) r.bridge_control_reg = 8'h81;
      if (i == 5) r.dual_link_control_reg[2:0] = TXM_DUAL;
      khz = 16'($urandom % 16384);
      wr(r);
      chk_outs(r);
    end
    r = '0;
    r.bridge_control_reg = 8'h80;
    wr(r);
    for (i = 0; i < 6; i++) begin
      pk(codes[i]);
      chk("vs_hs_pulse", {vs_o, hs_o}, vh[i]);
    end
    cfg.sync_evt_en = 1'b1;
    pk(PKT_VSS);
    chk("vs_hs_evt", {vs_o, hs_o}, 2'h3);
    tick();
    tick();
    chk("hs_evt_hold", hs_o, 1'b1);
    tick();
    repeat (2) @(negedge ref_clk);
    chk("hs_evt_end", {vs_o, hs_o}, 2'h2);
    // Width of two lines: the start line plus one more horizontal start
    pk(PKT_HSS);
    chk("vs_evt_hold", {vs_o, hs_o}, 2'h3);
    repeat (3) tick();
    pk(PKT_HSS);
    chk("vs_evt_end", {vs_o, hs_o}, 2'h1);
    repeat (3) tick();
    r.reset_control_reg = 8'h80;
    wr(r);
    pk(PKT_VSS);
    chk("sync_disabled", {vs_o, hs_o}, 2'h0);
    pix_run(2'h1);
    pix_run(2'h0);
    pix_run(2'h2);
    report_and_stop();
  end
endmodule
`default_nettype wire
